/* shared/strap_cfg_pkg.sv */
// Package with pin classes, register map, field layout and timing constants of the strap loader.
package strap_cfg_pkg;

	// Connection found on one multi-mode pin by the analog front end.
	typedef enum logic [1:0] {PIN_LOW, PIN_OPEN, PIN_HIGH, PIN_RES} pin_class_t;

	localparam int RES_IDX_W = 5;
	localparam int VOUT_W = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_PINS = 4;

	// One pin as seen by the front end: its class and the recognised resistor index.
	typedef struct packed {
		pin_class_t pin_class;
		logic [RES_IDX_W-1:0] res_idx;
	} pin_sample_t;

	localparam int PIN_SAMPLE_W = $bits(pin_sample_t);

	// Pin positions inside the pin bundle.
	localparam int PIN_ADDR0 = 0;
	localparam int PIN_ADDR1 = 1;
	localparam int PIN_FINE = 2;
	localparam int PIN_COARSE = 3;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] REG_SLAVE_ADDR = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_VOUT = 8'h10;
	localparam logic [ADDR_W-1:0] REG_VOUT_CEIL = 8'h14;
	localparam logic [ADDR_W-1:0] REG_UV_LIMIT = 8'h18;
	localparam logic [ADDR_W-1:0] REG_OV_LIMIT = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_PIN_STATE = 8'h20;

	// Control and status bit positions.
	localparam int CTRL_RESTORE = 0;
	localparam int ST_SAMPLED = 0;
	localparam int ST_UV = 1;
	localparam int ST_OV = 2;
	localparam int ST_PG_CHG = 3;
	localparam int EVT_W = 4;

	// Reset values.
	localparam logic [VOUT_W-1:0] VOUT_RESET = 12'h03C;
	localparam logic [VOUT_W-1:0] UV_RESET = 12'h000;
	localparam logic [VOUT_W-1:0] OV_RESET = 12'hFFF;
	localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;

	// Arithmetic constants of the voltage decode and power-good check, all in 10 mV units or percent.
	localparam logic [VOUT_W-1:0] COARSE_STEP = 12'h019;
	localparam int CEIL_PCT = 110;
	localparam int PG_PCT = 90;
	localparam int PCT_FULL = 100;

	// Pin settle time before a capture.
	localparam int SETTLE_TIME_NS = 100;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : strap_cfg_pkg

/* hw/strap_pin_config_loader.sv */
// Strap pin configuration loader with register port, monitor alerts and power-good output.
// How it works
// RQ1: Each pin arrives classed low, open, high or resistor to signal ground.
// RQ2: Pins are captured after reset release and again on each restore command.
// RQ3: Strap pins decode three states; two pins pick one of nine settings.
// RQ4: A resistor pin gives one of up to 31 recognised indexes.
// RQ5: Captured settings can be overwritten and read back over the register port.
// RQ6: Slave address and voltage ceiling come only from pins; others are writable.
// RQ7: The slave address is formed from the two address-select pins at capture.
// RQ8: The voltage ceiling is ten percent above the pin-selected output voltage.
// RQ9: Programmable under and over limits raise alerts on the measured voltage.
// RQ10: A power-good output is driven for use as an external reset.
// RQ11: Two strap voltage pins choose one of nine voltages, low-low lowest.
// RQ12: Two resistors give fine index plus 25 times coarse index in 10 mV.
// RQ13: Captured values hold between captures and change only on capture or write.
`timescale 1ns/100ps

module strap_pin_config_loader
	import strap_cfg_pkg::*;
#(
	parameter logic [6:0] ADDR_BASE = 7'h20,
	parameter int SETTLE = SETTLE_CYCLES
)(
	// Clock and reset.
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// Classified multi-mode pins from the analog front end.
	input wire pin_sample_t [NUM_PINS-1:0] PIN_IN,
	// Measured output voltage from the monitor converter, 10 mV units.
	input wire logic [VOUT_W-1:0] VOUT_MEAS,
	// Register port.
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [DATA_W-1:0] RDATA,
	// Results.
	output logic [6:0] SLAVE_ADDR,
	output logic [VOUT_W-1:0] VOUT_SET,
	output logic [VOUT_W-1:0] VOUT_CEIL,
	output logic POWER_GOOD,
	output logic IRQ
);

	typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_LOAD} load_state_t;

	localparam int SYNC_W = NUM_PINS * PIN_SAMPLE_W;
	localparam int CNT_W = $clog2(SETTLE + 1);

	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	pin_sample_t [NUM_PINS-1:0] pins;
	load_state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [VOUT_W-1:0] vout_reg;
	logic [VOUT_W-1:0] vout_next;
	logic [VOUT_W-1:0] ceil_reg;
	logic [VOUT_W-1:0] ceil_next;
	logic [6:0] addr_reg;
	logic [6:0] addr_next;
	logic [VOUT_W-1:0] uv_reg;
	logic [VOUT_W-1:0] ov_reg;
	logic [EVT_W-1:0] status_reg;
	logic [EVT_W-1:0] mask_reg;
	logic [EVT_W-1:0] events;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [SYNC_W-1:0] pin_state_reg;
	logic pg_reg;
	logic pg_next;
	logic irq_reg;
	logic restore_req;
	logic load;

	// Two-flop synchronisers on every pin bit; only the second stage is read.
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++)
		begin : g_sync
			always_ff @(posedge SYS_CLK)
			begin
				if (!RESET_N)
				begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
				end
				else
				begin
					sync1_reg[g] <= PIN_IN[g / PIN_SAMPLE_W][g % PIN_SAMPLE_W];
					sync2_reg[g] <= sync1_reg[g];
				end
			end
		end
	endgenerate

	assign pins = sync2_reg; // RQ1

	// Index of a strap class: low 0, open 1, high 2.
	function automatic logic [1:0] strap_idx(input pin_class_t c);
		strap_idx = (c == PIN_HIGH) ? 2'h2 : (c == PIN_OPEN) ? 2'h1 : 2'h0; // RQ3
	endfunction : strap_idx

	// Nine strap voltages, coarse pin picks the row, fine pin the column.
	function automatic logic [VOUT_W-1:0] strap_vout(input logic [1:0] coarse, input logic [1:0] fine);
		logic [3:0] sel;
		sel = 4'(coarse * 3 + fine); // RQ3
		case (sel) // RQ11
			4'h0: strap_vout = 12'h03C;
			4'h1: strap_vout = 12'h050;
			4'h2: strap_vout = 12'h064;
			4'h3: strap_vout = 12'h078;
			4'h4: strap_vout = 12'h096;
			4'h5: strap_vout = 12'h0B4;
			4'h6: strap_vout = 12'h0FA;
			4'h7: strap_vout = 12'h14A;
			4'h8: strap_vout = 12'h1F4;
			default: strap_vout = VOUT_RESET;
		endcase
	endfunction : strap_vout

	// Single coarse resistor with the fine pin low: 31 recognised settings.
	function automatic logic [VOUT_W-1:0] single_res_vout(input logic [RES_IDX_W-1:0] idx);
		case (idx) // RQ4
			5'h00: single_res_vout = 12'h03C;
			5'h01: single_res_vout = 12'h041;
			5'h02: single_res_vout = 12'h046;
			5'h03: single_res_vout = 12'h04B;
			5'h04: single_res_vout = 12'h050;
			5'h05: single_res_vout = 12'h055;
			5'h06: single_res_vout = 12'h05A;
			5'h07: single_res_vout = 12'h05F;
			5'h08: single_res_vout = 12'h064;
			5'h09: single_res_vout = 12'h069;
			5'h0A: single_res_vout = 12'h06E;
			5'h0B: single_res_vout = 12'h073;
			5'h0C: single_res_vout = 12'h078;
			5'h0D: single_res_vout = 12'h07D;
			5'h0E: single_res_vout = 12'h082;
			5'h0F: single_res_vout = 12'h08C;
			5'h10: single_res_vout = 12'h096;
			5'h11: single_res_vout = 12'h0A0;
			5'h12: single_res_vout = 12'h0AA;
			5'h13: single_res_vout = 12'h0B4;
			5'h14: single_res_vout = 12'h0BE;
			5'h15: single_res_vout = 12'h0C8;
			5'h16: single_res_vout = 12'h0D2;
			5'h17: single_res_vout = 12'h0DC;
			5'h18: single_res_vout = 12'h0E6;
			5'h19: single_res_vout = 12'h0FA;
			5'h1A: single_res_vout = 12'h12C;
			5'h1B: single_res_vout = 12'h14A;
			5'h1C: single_res_vout = 12'h190;
			5'h1D: single_res_vout = 12'h1F4;
			5'h1E: single_res_vout = 12'h226;
			default: single_res_vout = VOUT_RESET;
		endcase
	endfunction : single_res_vout

	// Voltage decode from the two voltage pins; mixed connections other than a coarse resistor with the fine pin low fall back to the low-low strap setting.
	always_comb
	begin
		if (pins[PIN_COARSE].pin_class == PIN_RES && pins[PIN_FINE].pin_class == PIN_RES)
			vout_next = VOUT_W'(pins[PIN_FINE].res_idx) + VOUT_W'(COARSE_STEP * pins[PIN_COARSE].res_idx); // RQ12
		else if (pins[PIN_COARSE].pin_class == PIN_RES && pins[PIN_FINE].pin_class == PIN_LOW)
			vout_next = single_res_vout(pins[PIN_COARSE].res_idx); // RQ4
		else if (pins[PIN_COARSE].pin_class != PIN_RES && pins[PIN_FINE].pin_class != PIN_RES)
			vout_next = strap_vout(strap_idx(pins[PIN_COARSE].pin_class), strap_idx(pins[PIN_FINE].pin_class));
		else
			vout_next = VOUT_RESET;
		ceil_next = VOUT_W'((32'(vout_next) * CEIL_PCT) / PCT_FULL); // RQ8
	end

	// Slave address from the two address pins: strap pairs give nine, a resistor on pin 0 gives its index.
	always_comb
	begin
		if (pins[PIN_ADDR0].pin_class == PIN_RES)
			addr_next = ADDR_BASE + 7'(pins[PIN_ADDR0].res_idx); // RQ7
		else
			addr_next = ADDR_BASE + 7'(strap_idx(pins[PIN_ADDR1].pin_class) * 3 + strap_idx(pins[PIN_ADDR0].pin_class)); // RQ7
	end

	assign restore_req = WR && ADDR == REG_CTRL && WDATA[CTRL_RESTORE];
	assign load = state_reg == S_LOAD;

	// Capture sequencer: settle after reset or restore, then load once.
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			state_reg <= S_SETTLE; // RQ2
			cnt_reg <= '0;
		end
		else
		begin
			case (state_reg)
				S_IDLE:
				begin
					cnt_reg <= '0;
					if (restore_req)
						state_reg <= S_SETTLE; // RQ2
				end
				S_SETTLE:
				begin
					if (cnt_reg == CNT_W'(SETTLE - 1))
						state_reg <= S_LOAD;
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				S_LOAD:
				begin
					cnt_reg <= '0;
					state_reg <= S_IDLE;
				end
				default:
				begin
					cnt_reg <= '0;
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// Pin-only settings: changed only by a capture.
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			addr_reg <= ADDR_BASE;
			ceil_reg <= VOUT_RESET;
			pin_state_reg <= '0;
		end
		else if (load)
		begin
			addr_reg <= addr_next; // RQ6
			ceil_reg <= ceil_next; // RQ6
			pin_state_reg <= sync2_reg; // RQ13
		end
	end

	// Output voltage setting: loaded by capture, overwritten by the host, never above the ceiling.
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
			vout_reg <= VOUT_RESET;
		else if (load)
			vout_reg <= vout_next; // RQ13
		else if (WR && ADDR == REG_VOUT)
			vout_reg <= (WDATA[VOUT_W-1:0] > ceil_reg) ? ceil_reg : WDATA[VOUT_W-1:0]; // RQ5
	end

	// Monitor limits set by the host.
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			uv_reg <= UV_RESET;
			ov_reg <= OV_RESET;
		end
		else if (WR && ADDR == REG_UV_LIMIT)
			uv_reg <= WDATA[VOUT_W-1:0]; // RQ9
		else if (WR && ADDR == REG_OV_LIMIT)
			ov_reg <= WDATA[VOUT_W-1:0]; // RQ9
	end

	// Power good once the measured voltage reaches 90 percent of the setting.
	assign pg_next = 32'(VOUT_MEAS) * PCT_FULL >= 32'(vout_reg) * PG_PCT;

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
			pg_reg <= 1'b0;
		else
			pg_reg <= pg_next; // RQ10
	end

	assign events[ST_SAMPLED] = load;
	assign events[ST_UV] = VOUT_MEAS < uv_reg; // RQ9
	assign events[ST_OV] = VOUT_MEAS > ov_reg; // RQ9
	assign events[ST_PG_CHG] = pg_next != pg_reg;

	// Sticky status, cleared by writing one; a new event wins over the clear.
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
			status_reg <= '0;
		else if (WR && ADDR == REG_STATUS)
			status_reg <= (status_reg & ~WDATA[EVT_W-1:0]) | events;
		else
			status_reg <= status_reg | events;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
			mask_reg <= MASK_RESET;
		else if (WR && ADDR == REG_MASK)
			mask_reg <= WDATA[EVT_W-1:0];
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(status_reg & mask_reg); // RQ9
	end

	// Read mux; unmapped addresses and idle cycles read zero.
	always_comb
	begin
		rdata_next = '0;
		if (RD)
		begin
			case (ADDR)
				REG_STATUS: rdata_next = DATA_W'(status_reg);
				REG_MASK: rdata_next = DATA_W'(mask_reg);
				REG_SLAVE_ADDR: rdata_next = DATA_W'(addr_reg);
				REG_VOUT: rdata_next = DATA_W'(vout_reg); // RQ5
				REG_VOUT_CEIL: rdata_next = DATA_W'(ceil_reg);
				REG_UV_LIMIT: rdata_next = DATA_W'(uv_reg);
				REG_OV_LIMIT: rdata_next = DATA_W'(ov_reg);
				REG_PIN_STATE: rdata_next = DATA_W'(pin_state_reg);
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
			rdata_reg <= '0;
		else
			rdata_reg <= rdata_next;
	end

	assign RDATA = rdata_reg;
	assign SLAVE_ADDR = addr_reg;
	assign VOUT_SET = vout_reg;
	assign VOUT_CEIL = ceil_reg;
	assign POWER_GOOD = pg_reg;
	assign IRQ = irq_reg;

endmodule : strap_pin_config_loader

/* verif/strap_pin_config_loader_asserts.sv */
// Port checker of the strap pin configuration loader.
`timescale 1ns/100ps
module strap_cfg_chk
	import strap_cfg_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYCLES
)(
	// Clock and reset.
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// Pins and monitor.
	input wire pin_sample_t [NUM_PINS-1:0] PIN_IN,
	input wire logic [VOUT_W-1:0] VOUT_MEAS,
	// Register port.
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [DATA_W-1:0] RDATA,
	// Results.
	input wire logic [6:0] SLAVE_ADDR,
	input wire logic [VOUT_W-1:0] VOUT_SET,
	input wire logic [VOUT_W-1:0] VOUT_CEIL,
	input wire logic POWER_GOOD,
	input wire logic IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	chk_read_idle: assert property (!RD |=> RDATA == '0) else $error("read data outside slot");
	chk_unmapped_zero: assert property (RD && ADDR > REG_PIN_STATE |=> RDATA == '0) else $error("unmapped");
	chk_vout_readback: assert property (RD && ADDR == REG_VOUT |=> RDATA == 32'($past(VOUT_SET)))
		else $error("vout readback");
	chk_ceil_readback: assert property (RD && ADDR == REG_VOUT_CEIL |=> RDATA == 32'($past(VOUT_CEIL)))
		else $error("ceiling readback");
	chk_vout_write: assert property (WR && ADDR == REG_VOUT && WDATA[11:0] <= VOUT_CEIL
		|=> VOUT_SET == $past(WDATA[11:0])) else $error("vout write");
	chk_write_capped: assert property (WR && ADDR == REG_VOUT && WDATA[11:0] > VOUT_CEIL
		|=> VOUT_SET == $past(VOUT_CEIL)) else $error("vout cap");
	chk_ceil_ro: assert property (WR && ADDR == REG_VOUT_CEIL |=> $stable(VOUT_CEIL)) else $error("ceiling written");
	chk_addr_ro: assert property (WR && ADDR == REG_SLAVE_ADDR |=> $stable(SLAVE_ADDR)) else $error("address written");
	chk_set_under_ceil: assert property (VOUT_SET <= VOUT_CEIL) else $error("vout above ceiling");
	chk_pg_level: assert property ($past(RESET_N) |-> POWER_GOOD == (32'($past(VOUT_MEAS)) * 100
		>= 32'($past(VOUT_SET)) * 90)) else $error("power good level");

	cover property (WR && ADDR == REG_CTRL && WDATA[CTRL_RESTORE]);
	cover property ($rose(IRQ));
	cover property ($fell(POWER_GOOD));
endmodule : strap_cfg_chk

bind strap_pin_config_loader strap_cfg_chk #(.SETTLE(SETTLE)) chk_u (.SYS_CLK, .RESET_N, .PIN_IN, .VOUT_MEAS,
	.ADDR, .WDATA, .WR, .RD, .RDATA, .SLAVE_ADDR, .VOUT_SET, .VOUT_CEIL, .POWER_GOOD, .IRQ);

/* verif/strap_pins_model.sv */
// Board strap connections and output voltage monitor seen by the loader.
`timescale 1ns/100ps
module strap_pins_model
	import strap_cfg_pkg::*;
(
	// Requested board connections and rail voltage.
	input wire pin_sample_t [NUM_PINS-1:0] conn,
	input wire logic [VOUT_W-1:0] rail,
	// Toward the loader.
	output pin_sample_t [NUM_PINS-1:0] pins,
	output logic [VOUT_W-1:0] meas
);
	always_comb
	begin
		for (int i = 0; i < NUM_PINS; i++)
		begin
			pins[i].pin_class = conn[i].pin_class;
			// Without a resistor the index lines mean nothing, so they show a changed pattern.
			pins[i].res_idx = (conn[i].pin_class == PIN_RES) ? conn[i].res_idx : ~conn[i].res_idx;
		end
	end

	assign meas = rail;
endmodule : strap_pins_model

/* verif/tb_strap_pin_config_loader.sv */
// Self-checking bench of the strap pin configuration loader.
`timescale 1ns/100ps
module tb_strap_pin_config_loader
	import strap_cfg_pkg::*;
;
	// The default settle count is used: a capture needs the pin synchronisers to have filled after reset.
	localparam int SETTLE_T = SETTLE_CYCLES;
	logic SYS_CLK = 1'b0;
	logic RESET_N = 1'b0;
	pin_sample_t [NUM_PINS-1:0] conn, pin_in;
	logic [VOUT_W-1:0] rail, vout_meas, vout_set, vout_ceil;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, rv;
	logic wr = 1'b0, rd = 1'b0, power_good, irq;
	logic [6:0] slave_addr;
	int err_total = 0, cmp_count = 0;
	int vt [9] = '{60, 80, 100, 120, 150, 180, 250, 330, 500};

	always #10 SYS_CLK = ~SYS_CLK;

	strap_pins_model pm_u (.conn(conn), .rail(rail), .pins(pin_in), .meas(vout_meas));
	strap_pin_config_loader #(.SETTLE(SETTLE_T)) dut_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PIN_IN(pin_in),
		.VOUT_MEAS(vout_meas), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.SLAVE_ADDR(slave_addr), .VOUT_SET(vout_set), .VOUT_CEIL(vout_ceil), .POWER_GOOD(power_good), .IRQ(irq));

	task automatic complete_run();
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge SYS_CLK);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge SYS_CLK);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge SYS_CLK);
		rd <= 1'b1;
		addr <= a;
		@(posedge SYS_CLK);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	function automatic pin_sample_t ps(input int c, input int i);
		return {2'(c), 5'(i)};
	endfunction : ps

	// Pins are held for two edges so the synchronisers have settled before any capture.
	task automatic setpins(input pin_sample_t a0, a1, fine, coarse);
		@(posedge SYS_CLK);
		conn <= {coarse, fine, a1, a0};
		repeat (2) @(posedge SYS_CLK);
	endtask : setpins

	task automatic restore();
		wr_reg(REG_CTRL, 32'h1);
		repeat (SETTLE_T + 3) @(posedge SYS_CLK);
		#1;
	endtask : restore

	initial
	begin
		repeat (5000) @(posedge SYS_CLK);
		err_total++;
		complete_run();
	end

	initial
	begin
		rail = 12'h000;
		conn = {ps(2, 0), ps(1, 0), ps(1, 0), ps(2, 0)};
		repeat (12) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		repeat (SETTLE_T + 4) @(posedge SYS_CLK);
		#1;
		chk(32'(slave_addr), 32'h25);
		chk(32'(vout_set), 32'h14A);
		chk(32'(vout_ceil), 32'h16B);
		for (int c = 0; c < 3; c++)
			for (int f = 0; f < 3; f++)
			begin
				setpins(ps(f, 0), ps(c, 0), ps(f, 0), ps(c, 0));
				restore();
				chk(32'(vout_set), 32'(vt[c * 3 + f]));
				rd_reg(REG_VOUT_CEIL, rv);
				chk(rv, 32'(vt[c * 3 + f] * 110 / 100));
				chk(32'(slave_addr), 32'(32 + 3 * c + f));
			end
		setpins(ps(0, 0), ps(0, 0), ps(0, 0), ps(3, 30));
		restore();
		chk(32'(vout_set), 32'h226);
		chk(32'(vout_ceil), 32'h25D);
		chk(32'(slave_addr), 32'h20);
		setpins(ps(1, 0), ps(2, 0), ps(3, 4), ps(2, 0));
		restore();
		chk(32'(vout_set), 32'h3C);
		chk(32'(vout_ceil), 32'h42);
		chk(32'(slave_addr), 32'h27);
		rd_reg(REG_PIN_STATE, rv);
		chk(rv, 32'(pin_in));
		setpins(ps(3, 9), ps(0, 0), ps(3, 8), ps(3, 5));
		restore();
		chk(32'(vout_set), 32'h85);
		chk(32'(vout_ceil), 32'h92);
		chk(32'(slave_addr), 32'h29);
		setpins(ps(2, 0), ps(2, 0), ps(2, 0), ps(2, 0));
		chk(32'(vout_set), 32'h85);
		chk(32'(slave_addr), 32'h29);
		wr_reg(REG_VOUT, 32'h64);
		rd_reg(REG_VOUT, rv);
		chk(rv, 32'h64);
		wr_reg(REG_VOUT, 32'hFFF);
		rd_reg(REG_VOUT, rv);
		chk(rv, 32'h92);
		wr_reg(REG_SLAVE_ADDR, 32'h7F);
		wr_reg(REG_VOUT_CEIL, 32'hFFF);
		rd_reg(REG_SLAVE_ADDR, rv);
		chk(rv, 32'h29);
		rd_reg(REG_VOUT_CEIL, rv);
		chk(rv, 32'h92);
		rd_reg(8'h40, rv);
		chk(rv, 32'h0);
		wr_reg(REG_STATUS, 32'hF);
		rd_reg(REG_STATUS, rv);
		chk(rv, 32'h0);
		wr_reg(REG_MASK, 32'h2);
		wr_reg(REG_UV_LIMIT, 32'h50);
		rd_reg(REG_STATUS, rv);
		chk(rv, 32'h2);
		chk(32'(irq), 32'h1);
		@(posedge SYS_CLK);
		rail <= 12'd146;
		repeat (3) @(posedge SYS_CLK);
		#1;
		chk(32'(power_good), 32'h1);
		wr_reg(REG_STATUS, 32'hF);
		rd_reg(REG_STATUS, rv);
		chk(rv, 32'h0);
		chk(32'(irq), 32'h0);
		@(posedge SYS_CLK);
		rail <= 12'd100;
		repeat (3) @(posedge SYS_CLK);
		#1;
		chk(32'(power_good), 32'h0);
		rd_reg(REG_STATUS, rv);
		chk(rv, 32'h8);
		chk(32'(irq), 32'h0);
		wr_reg(REG_OV_LIMIT, 32'h50);
		wr_reg(REG_MASK, 32'h4);
		rd_reg(REG_STATUS, rv);
		chk(rv, 32'hC);
		chk(32'(irq), 32'h1);
		rd_reg(REG_OV_LIMIT, rv);
		chk(rv, 32'h50);
		complete_run();
	end
endmodule : tb_strap_pin_config_loader
